/* File: core/nand_host_regs.vh */
`ifndef NAND_HOST_REGS_VH
`define NAND_HOST_REGS_VH

// flash commands
`define CMD_READ_MAIN      8'h00
`define CMD_READ_SPARE     8'h50
`define CMD_ERASE_SETUP    8'h60
`define CMD_ERASE_CONFIRM  8'hd0
`define CMD_STATUS         8'h70
`define CMD_IDENT          8'h90
`define CMD_RESET          8'hff
`define ADDR_IDENT         8'h00

// status byte fields
`define ST_FAIL_BIT        0
`define ST_READY_BIT       6
`define ST_WP_BIT          7
`define ST_RESET_VALUE     8'hc0

// erase block address: flash bits a14..a24 inside a9..a24
`define BLK_LSB            5
`define BLK_WIDTH          11

// control register offsets
`define REG_CTRL           4'h0
`define REG_BLOCK          4'h1
`define REG_STATUS         4'h2
`define REG_FLASH_STATUS   4'h3
`define REG_ID_MAKER       4'h4
`define REG_ID_DEVICE      4'h5

// ctrl write opcodes in wdata[2:0]
`define OP_ERASE           3'h1
`define OP_STATUS          3'h2
`define OP_IDENT           3'h3
`define OP_RESET           3'h4
`define OP_READ_MAIN       3'h5
// ctrl bit 8: write protect release
`define CTRL_WP_BIT        8

// timing
`define T_RECOVER_NS       10000
`define CLK_NS             20
`define RECOVER_CYC        ((`T_RECOVER_NS + `CLK_NS - 1) / `CLK_NS)
`define T_STROBE_CYC       3
`define BUSY_TIMEOUT_CYC   22'h3fffff

`endif

/* File: core/nand_host.v */
`timescale 1ns/10ps
`include "nand_host_regs.vh"

// Function
// - erase sends 60h then two address cycles carrying the block
// - erase is completed by sending d0h after the address cycles
// - status read: 70h, then read cycles with chip and read enable low
// - host sends 00h before resuming page reads after status mode
// - identification: 90h then a single 00h address cycle
// - write protect low at power up, 10 us before first command
// - while busy only status read and reset are sent
module nand_host (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // register port
    input  wire [3:0]  addr_i,
    input  wire [15:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [15:0] rdata_o,
    // flash pins
    output reg         ce_n_o,
    output reg         cle_o,
    output reg         ale_o,
    output reg         we_n_o,
    output reg         output_strobe_n_o,
    output reg         wp_n_o,
    output reg  [7:0]  io_o,
    output reg         io_oe_n_o,
    input  wire [7:0]  io_i,
    input  wire        rb_i
);

////////////////////////////////////////////////////////////////////////
// state codes
localparam S_POWER   = 4'd0;
localparam S_IDLE    = 4'd1;
localparam S_WCMD    = 4'd2;
localparam S_WADDR   = 4'd3;
localparam S_WAITB   = 4'd4;
localparam S_WAITR   = 4'd5;
localparam S_READ    = 4'd6;
localparam S_DONE    = 4'd7;

// recovery end and strobe phases, cut to counter width at use
localparam [31:0] REC_LAST = `RECOVER_CYC;
localparam [31:0] PH_LOW   = `T_STROBE_CYC;
localparam [31:0] PH_HIGH  = 2 * `T_STROBE_CYC;
localparam [31:0] PH_END   = 2 * `T_STROBE_CYC + 1;

reg  [3:0]  state;
reg  [13:0] rec_cnt;
reg  [2:0]  ph;
reg  [21:0] tmo;
reg  [2:0]  op;
reg  [1:0]  seq;
reg  [10:0] block;
reg  [7:0]  flash_status;
reg  [7:0]  id_maker;
reg  [7:0]  id_device;
reg         busy;
reg         err;
reg         wp_rel;
reg         status_mode;
reg  [7:0]  byte_out;
reg         byte_cmd;
reg  [2:0]  rb_sync;
reg         rb_level;
reg  [7:0]  io_s1;
reg  [7:0]  io_s2;
reg  [7:0]  io_s3;
reg  [7:0]  io_level;

////////////////////////////////////////////////////////////////////////
// pin synchronisers
always @(posedge clk_i) begin
    if (rst_i) begin
        rb_sync  <= 3'h7;
        rb_level <= 1'b1;
        io_s1    <= 8'h00;
        io_s2    <= 8'h00;
        io_s3    <= 8'h00;
        io_level <= 8'h00;
    end else begin
        rb_sync <= {rb_sync[1:0], rb_i};
        if (rb_sync[2] == rb_sync[1])
            rb_level <= rb_sync[1];
        io_s1 <= io_i;
        io_s2 <= io_s1;
        io_s3 <= io_s2;
        if (io_s3 == io_s2)
            io_level <= io_s2;
    end
end

////////////////////////////////////////////////////////////////////////
// register reads
always @(posedge clk_i) begin
    if (rst_i) begin
        rdata_o <= 16'h0000;
    end else if (rd_i) begin
        case (addr_i)
            `REG_CTRL:         rdata_o <= {7'h00, wp_rel, 5'h00, op};
            `REG_BLOCK:        rdata_o <= {5'h00, block};
            `REG_STATUS:       rdata_o <= {13'h0000, status_mode, err, busy};
            `REG_FLASH_STATUS: rdata_o <= {8'h00, flash_status};
            `REG_ID_MAKER:     rdata_o <= {8'h00, id_maker};
            `REG_ID_DEVICE:    rdata_o <= {8'h00, id_device};
            default:           rdata_o <= 16'h0000;
        endcase
    end else begin
        rdata_o <= 16'h0000;
    end
end

////////////////////////////////////////////////////////////////////////
// sequencer
always @(posedge clk_i) begin
    if (rst_i) begin
        state             <= S_POWER;
        rec_cnt           <= 14'h0000;
        ph                <= 3'h0;
        tmo               <= 22'h000000;
        op                <= 3'h0;
        seq               <= 2'h0;
        block             <= 11'h000;
        flash_status      <= 8'h00;
        id_maker          <= 8'h00;
        id_device         <= 8'h00;
        busy              <= 1'b1;
        err               <= 1'b0;
        wp_rel            <= 1'b0;
        status_mode       <= 1'b0;
        byte_out          <= 8'h00;
        byte_cmd          <= 1'b0;
        ce_n_o            <= 1'b1;
        cle_o             <= 1'b0;
        ale_o             <= 1'b0;
        we_n_o            <= 1'b1;
        output_strobe_n_o <= 1'b1;
        wp_n_o            <= 1'b0;
        io_o              <= 8'h00;
        io_oe_n_o         <= 1'b1;
    end else begin
        if (wr_i && addr_i == `REG_BLOCK && !busy)
            block <= wdata_i[10:0];
        if (wr_i && addr_i == `REG_CTRL)
            wp_rel <= wdata_i[`CTRL_WP_BIT];
        case (state)
            S_POWER: begin
                if (rec_cnt == REC_LAST[13:0]) begin
                    state <= S_IDLE;
                    busy  <= 1'b0;
                end else begin
                    rec_cnt <= rec_cnt + 14'h0001;
                end
            end
            S_IDLE: begin
                wp_n_o <= wp_rel;
                if (wr_i && addr_i == `REG_CTRL && wdata_i[2:0] != 3'h0) begin
                    op     <= wdata_i[2:0];
                    seq    <= 2'h0;
                    ce_n_o <= 1'b0;
                    busy   <= 1'b1;
                    err    <= 1'b0;
                    status_mode <= 1'b0;
                    state  <= S_WCMD;
                    byte_cmd  <= 1'b1;
                    io_oe_n_o <= 1'b0;
                    case (wdata_i[2:0])
                        `OP_ERASE:  byte_out <= `CMD_ERASE_SETUP;
                        `OP_STATUS: byte_out <= `CMD_STATUS;
                        `OP_IDENT:  byte_out <= `CMD_IDENT;
                        `OP_RESET:  byte_out <= `CMD_RESET;
                        default:    byte_out <= `CMD_READ_MAIN;
                    endcase
                end
            end
            S_WCMD, S_WADDR: begin
                // one write cycle: setup, strobe low, strobe high
                ph <= ph + 3'h1;
                if (ph == 3'h0) begin
                    cle_o <= byte_cmd;
                    ale_o <= ~byte_cmd;
                    io_o  <= byte_out;
                end else if (ph == PH_LOW[2:0]) begin
                    we_n_o <= 1'b0;
                end else if (ph == PH_HIGH[2:0]) begin
                    we_n_o <= 1'b1;
                end else if (ph == PH_END[2:0]) begin
                    ph    <= 3'h0;
                    cle_o <= 1'b0;
                    ale_o <= 1'b0;
                    seq   <= seq + 2'h1;
                    tmo   <= 22'h000000;
                    byte_cmd <= 1'b0;
                    case (op)
                        `OP_ERASE: begin
                            if (seq == 2'h0) begin
                                byte_out <= {block[2:0], {`BLK_LSB{1'b0}}};
                                state <= S_WADDR;
                            end else if (seq == 2'h1) begin
                                byte_out <= block[10:3];
                            end else if (seq == 2'h2) begin
                                byte_out <= `CMD_ERASE_CONFIRM;
                                byte_cmd <= 1'b1;
                                state <= S_WCMD;
                            end else begin
                                io_oe_n_o <= 1'b1;
                                state <= S_WAITB;
                            end
                        end
                        `OP_IDENT: begin
                            if (seq == 2'h0) begin
                                byte_out <= `ADDR_IDENT;
                                state <= S_WADDR;
                            end else begin
                                io_oe_n_o <= 1'b1;
                                state <= S_READ;
                            end
                        end
                        `OP_RESET: begin
                            io_oe_n_o <= 1'b1;
                            state <= S_WAITB;
                        end
                        `OP_STATUS: begin
                            io_oe_n_o <= 1'b1;
                            status_mode <= 1'b1;
                            state <= S_READ;
                        end
                        default: begin
                            io_oe_n_o <= 1'b1;
                            status_mode <= 1'b0;
                            state <= S_DONE;
                        end
                    endcase
                end
            end
            S_WAITB: begin
                // busy may be too short to see; give it a bounded window
                tmo <= tmo + 22'h000001;
                if (!rb_level || tmo == 22'h0000ff)
                    state <= S_WAITR;
            end
            S_WAITR: begin
                tmo <= tmo + 22'h000001;
                if (rb_level) begin
                    op    <= `OP_STATUS;
                    state <= S_WCMD;
                    byte_out  <= `CMD_STATUS;
                    byte_cmd  <= 1'b1;
                    io_oe_n_o <= 1'b0;
                    seq   <= 2'h0;
                end else if (tmo == `BUSY_TIMEOUT_CYC) begin
                    err   <= 1'b1;
                    state <= S_DONE;
                end
            end
            S_READ: begin
                ph <= ph + 3'h1;
                if (ph == 3'h0) begin
                    output_strobe_n_o <= 1'b0;
                end else if (ph == PH_HIGH[2:0]) begin
                    output_strobe_n_o <= 1'b1;
                    ph <= 3'h0;
                    if (status_mode) begin
                        flash_status <= io_level;
                        if (io_level[`ST_READY_BIT])
                            state <= S_DONE;
                    end else if (seq == 2'h2) begin
                        id_maker <= io_level;
                        seq <= 2'h3;
                    end else begin
                        id_device <= io_level;
                        state <= S_DONE;
                    end
                end
            end
            S_DONE: begin
                if (status_mode)
                    err <= err | flash_status[`ST_FAIL_BIT];
                ce_n_o <= 1'b1;
                busy   <= 1'b0;
                state  <= S_IDLE;
            end
            default: state <= S_IDLE;
        endcase
    end
end

endmodule // nand_host

/* File: tb/nand_dev.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////
module nand_dev #(
    parameter [7:0] MAKER  = 8'h3c, // arbitrary value
    parameter [7:0] DEVICE = 8'h5a  // arbitrary value
) (
    // strobes and controls
    input  wire       clk_i, ce_n_i, cle_i, ale_i,
    input  wire       we_n_i, strobe_n_i, wp_n_i,
    // data and ready/busy
    input  wire [7:0] io_i,
    output wire [7:0] io_o,
    output wire       rb_o
);
    integer    busy = 0, busy_len = 4, mode = 0, step = 0, rid = 0;
    integer    erases = 0;
    reg [7:0]  a1 = 8'h00, last = 8'h00;
    reg [10:0] blk = 11'h000;
    reg        fail = 1'b0, fail_next = 1'b0;
    wire [7:0] st = {wp_n_i, busy == 0, 5'h00, fail};
    wire       drv = !ce_n_i && !strobe_n_i &&
                     mode > 0 && mode < 3;
    wire [7:0] rv = (mode == 2) ?
                    (rid == 0 ? MAKER : DEVICE) : st;
    assign io_o = drv ? rv : ~last;
    assign rb_o = (busy > 0) ? 1'b0 : 1'b1; // pulled-up
    always @(posedge clk_i) begin
        if (drv) last <= rv;
        if (busy > 0) busy <= busy - 1;
    end
    always @(posedge strobe_n_i) if (mode == 2) rid = rid + 1;
    always @(posedge we_n_i) if (!ce_n_i && ale_i && step > 0) begin
        if (step == 1) a1 = io_i;
        else blk = {io_i, a1[7:5]};
        step = step + 1;
    end else if (!ce_n_i && cle_i && (busy == 0 ||
                 io_i == 8'h70 || io_i == 8'hff)) begin
        if (io_i == 8'hd0 && step == 3) begin
            erases = erases + 1;
            fail = fail_next;
            busy = busy_len;
        end
        step = (io_i == 8'h60) ? 1 : 0;
        if (io_i == 8'h70) mode = 1;
        if (io_i == 8'h90) mode = 2;
        if (io_i == 8'h90) rid = 0;
        if (io_i == 8'h00 || io_i == 8'h50) mode = 0;
        if (io_i == 8'hff && mode != 3) begin
            mode = 3;
            fail = 1'b0;
            busy = 20;
        end
    end
endmodule // nand_dev

/* File: tb/nand_host_chk.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////
module nand_host_chk (
    // clock, reset, register port
    input wire clk_i, rst_i, wr_i, rd_i,
    input wire [3:0] addr_i,
    input wire [15:0] wdata_i, rdata_o,
    // flash pins
    input wire ce_n_o, cle_o, ale_o, we_n_o, output_strobe_n_o,
    input wire wp_n_o, io_oe_n_o, rb_i,
    input wire [7:0] io_o, io_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    reg [7:0] cmd;
    reg [1:0] na;
    reg [9:0] since;
    always @(posedge clk_i) begin
        if (rst_i) begin
            cmd <= 8'h00;
            na <= 2'h0;
            since <= 10'h000;
        end else begin
            if (since < 10'h3ff) since <= since + 10'h001;
            if ($rose(we_n_o) && cle_o) cmd <= io_o;
            if ($rose(we_n_o) && cle_o) na <= 2'h0;
            else if ($rose(we_n_o) && ale_o && na < 2'h3) na <= na + 2'h1;
        end
    end
    AST_RST_PINS: assert property ($fell(rst_i) |->
        ce_n_o && we_n_o && output_strobe_n_o && !wp_n_o && io_oe_n_o)
        else $error("pins not idle after reset");
    AST_RECOVER: assert property (
        since < 10'h1f4 |-> we_n_o && !wp_n_o)
        else $error("flash touched during recovery");
    AST_WE_PULSE: assert property (
        $fell(we_n_o) |-> (!we_n_o)[*3] ##1 we_n_o)
        else $error("write strobe width wrong");
    AST_WE_HOLD: assert property (!we_n_o |=> we_n_o ||
        ($stable(io_o) && $stable(cle_o) && $stable(ale_o)))
        else $error("write cycle not held");
    AST_ROLE: assert property (
        !we_n_o |-> (cle_o ^ ale_o) && !ce_n_o && !io_oe_n_o)
        else $error("bad write cycle roles");
    AST_READ: assert property (!output_strobe_n_o |->
        !ce_n_o && we_n_o && io_oe_n_o && !cle_o && !ale_o)
        else $error("bad read cycle");
    AST_BLK_LOW: assert property (!we_n_o && ale_o &&
        cmd == 8'h60 && na == 2'h0 |-> io_o[4:0] == 5'h00)
        else $error("low address bits set");
    AST_CONFIRM: assert property (!we_n_o && cle_o &&
        io_o == 8'hd0 |-> cmd == 8'h60 && na == 2'h2)
        else $error("confirm out of order");
    AST_IDENT: assert property (!we_n_o && ale_o &&
        cmd == 8'h90 |-> io_o == 8'h00 && na == 2'h0)
        else $error("bad ident address");
    AST_BUSY_CMD: assert property (!we_n_o && cle_o &&
        !rb_i |-> io_o == 8'h70 || io_o == 8'hff)
        else $error("command while busy");
    AST_RDATA: assert property (
        rd_i && addr_i > 4'h5 |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    C_ERASE: cover property (!we_n_o && cle_o && io_o == 8'hd0);
    C_IDENT: cover property (!we_n_o && cle_o && io_o == 8'h90);
    C_RESET: cover property (!we_n_o && cle_o && io_o == 8'hff);
endmodule // nand_host_chk
bind nand_host nand_host_chk nand_host_chk_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .rdata_o(rdata_o), .ce_n_o(ce_n_o), .cle_o(cle_o), .ale_o(ale_o),
    .we_n_o(we_n_o), .output_strobe_n_o(output_strobe_n_o), .wp_n_o(wp_n_o),
    .io_oe_n_o(io_oe_n_o), .rb_i(rb_i), .io_o(io_o), .io_i(io_i));

/* File: tb/tb.sv */
`timescale 1ns/10ps
`include "nand_host_regs.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
////////////////////////////////////////////////////////////////////////////
module tb;
    localparam [7:0] MK = 8'h3c, DV = 8'h5a;
    reg         clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0;
    reg  [3:0]  addr_i = 4'h0;
    reg  [15:0] wdata_i = 16'h0000, q = 16'h0000;
    reg  [10:0] b;
    wire [15:0] rdata_o;
    wire [7:0]  hio, dio;
    wire        ce_n, cle, ale, we_n, strobe_n, wp_n, oe_n, rb;
    integer     failures = 0, comparisons = 0, cyc = 0, i, seed = 47658;
    initial forever #10 clk_i = ~clk_i;
    nand_host nand_host_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .ce_n_o(ce_n), .cle_o(cle), .ale_o(ale), .we_n_o(we_n),
        .output_strobe_n_o(strobe_n), .wp_n_o(wp_n), .io_o(hio),
        .io_oe_n_o(oe_n), .io_i(dio), .rb_i(rb));
    nand_dev #(.MAKER(MK), .DEVICE(DV)) nand_dev_inst (.clk_i(clk_i),
        .ce_n_i(ce_n), .cle_i(cle), .ale_i(ale), .we_n_i(we_n),
        .strobe_n_i(strobe_n), .wp_n_i(wp_n), .io_i(hio), .io_o(dio),
        .rb_o(rb));
    task wrap_up;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task wr(input [3:0] a, input [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task rd(input [3:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 q = rdata_o;
    endtask
    task idle;
        integer n;
        n = 0;
        q = 16'h0001;
        while (q[0] !== 1'b0 && n < 3000) begin
            rd(`REG_STATUS);
            n = n + 1;
        end
    endtask
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (cyc == 80000) begin
            failures++;
            wrap_up;
        end
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        idle;
        `CHK(wp_n, 1'b0)
        wr(`REG_CTRL, 16'h0100);
        wr(`REG_CTRL, 16'h0100 | `OP_IDENT);
        idle;
        rd(`REG_ID_MAKER);
        `CHK(q, {8'h00, MK})
        rd(`REG_ID_DEVICE);
        `CHK(q, {8'h00, DV})
        for (i = 0; i < 4; i = i + 1) begin
            b = $random(seed);
            nand_dev_inst.fail_next = i[0];
            nand_dev_inst.busy_len = (i < 2) ? 4 : 150 + i;
            wr(`REG_BLOCK, {5'h00, b});
            wr(`REG_CTRL, 16'h0100 | `OP_ERASE);
            wr(`REG_CTRL, 16'h0100 | `OP_IDENT);
            idle;
            `CHK(nand_dev_inst.blk, b)
            `CHK(nand_dev_inst.erases, i + 1)
            `CHK(nand_dev_inst.mode, 1)
            rd(`REG_FLASH_STATUS);
            `CHK(q, {8'h00, 2'b11, 5'h00, i[0]})
            rd(`REG_STATUS);
            `CHK(q[2:1], {1'b1, i[0]})
        end
        rd(`REG_BLOCK);
        `CHK(q, {5'h00, b})
        for (i = 0; i < 2; i = i + 1) begin
            wr(`REG_CTRL, 16'h0100 | `OP_RESET);
            idle;
            rd(`REG_FLASH_STATUS);
            `CHK(q, {8'h00, `ST_RESET_VALUE})
        end
        wr(`REG_CTRL, 16'h0000);
        wr(`REG_CTRL, {13'h0000, `OP_STATUS});
        idle;
        rd(`REG_FLASH_STATUS);
        `CHK(q, 16'h0040)
        rd(`REG_CTRL);
        `CHK(q, {13'h0000, `OP_STATUS})
        wr(`REG_CTRL, 16'h0100 | `OP_IDENT);
        idle;
        rd(`REG_STATUS);
        `CHK(q[2], 1'b0)
        rd(`REG_ID_DEVICE);
        `CHK(q, {8'h00, DV})
        rd(`REG_FLASH_STATUS);
        `CHK(q, 16'h0040)
        wr(`REG_CTRL, 16'h0100 | `OP_READ_MAIN);
        idle;
        `CHK(nand_dev_inst.mode, 0)
        rd(4'hf);
        `CHK(q, 16'h0000)
        wrap_up;
    end
endmodule // tb
